// ### hw/uidmap_bank.sv
// unique id low quadlet, config rom mapping and posted write error capture, behind an apb slave
// assumes synchronous inputs on core_clk; global_reset_n is the only source that clears the id
//------------------------------------------------------------
// Functional notes
//------------------------------------------------------------
// Functional notes
// - a global reset clears the lower id quadlet to zero.
// - only the global reset touches the lower id; software resets leave it alone.
// - the lower id loads and locks and is read-only to software.
// - the id loads once from eeprom or firmware after global reset, then locks.
// - bits 31 to 10 of the rom mapping register hold a read/write base address.
// - a quadlet read in the rom window maps to base plus the offset's ten low bits.
// - bits 9 to 0 of the rom mapping register read as zero.
// - a failed posted write updates both error registers.
// - the low error register takes the lower 32 bits of the failed offset.
// - the high error register takes bus number in 31-22 and node number in 21-16.
// - the high error register takes the upper 16 offset bits in 15-0.
`timescale 1ns/1ps
`include "uidmap_regs.svh"

module uidmap_bank (
    // clock and resets
    input  wire logic                        core_clk,
    input  wire logic                        rst_b,
    input  wire logic                        global_reset_n,
    input  wire logic                        soft_reset,
    // register bus
    input  wire uidmap_pkg::uidmap_apb_req_t apb_req,
    output      uidmap_pkg::uidmap_apb_rsp_t apb_rsp,
    // id load source
    input  wire logic                        id_load_valid,
    input  wire logic [31:0]                 chip_serial_low,
    // link side
    input  wire uidmap_pkg::uidmap_rom_req_t rom_req,
    output      uidmap_pkg::uidmap_rom_rsp_t rom_rsp,
    input  wire uidmap_pkg::uidmap_wr_fail_t wr_fail,
    // interrupt
    output      logic                        irq
);
    import uidmap_pkg::*;

    //------------------------------------------------------------
    // reset release
    //------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic       rst_n;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    logic [1:0] global_reset_n_sync_reg;
    logic       global_reset_n_n;
    always_ff @(posedge core_clk or negedge global_reset_n) begin
        if (!global_reset_n) begin
            global_reset_n_sync_reg <= 2'b00;
        end else begin
            global_reset_n_sync_reg <= {global_reset_n_sync_reg[0], 1'b1};
        end
    end
    assign global_reset_n_n = global_reset_n_sync_reg[1];

    //------------------------------------------------------------
    // apb slave
    //------------------------------------------------------------
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        return a[11:2] == off[11:2];
    endfunction

    uidmap_apb_state_t apb_state_reg;
    logic              setup;
    logic              wr_stb;
    assign setup  = apb_req.psel && !apb_req.penable;
    assign wr_stb = apb_req.psel && apb_req.penable && apb_req.pwrite;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            apb_state_reg <= UIDMAP_IDLE;
        end else begin
            apb_state_reg <= setup ? UIDMAP_ACCESS : UIDMAP_IDLE;
        end
    end

    //------------------------------------------------------------
    // lower unique id
    //------------------------------------------------------------
    logic [31:0] uid_low_reg;
    logic        uid_lock_reg;
    // cleared by global reset, loaded once, locked
    always_ff @(posedge core_clk or negedge global_reset_n_n) begin
        if (!global_reset_n_n) begin
            uid_low_reg  <= `UIDMAP_UID_RESET;
            uid_lock_reg <= 1'b0;
        end else if (!uid_lock_reg && id_load_valid) begin
            uid_low_reg  <= chip_serial_low;
            uid_lock_reg <= 1'b1;
        end
    end

    //------------------------------------------------------------
    // rom mapping
    //------------------------------------------------------------
    logic [21:0] rom_base_reg;
    // base read/write, cleared by hardware or soft reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rom_base_reg <= `UIDMAP_MAP_RESET;
        end else if (soft_reset) begin
            rom_base_reg <= `UIDMAP_MAP_RESET;
        end else if (wr_stb && hit(apb_req.paddr, `UIDMAP_OFF_ROM_MAP)) begin
            rom_base_reg <= apb_req.pwdata[31:`UIDMAP_MAP_LSB];
        end
    end

    logic rom_in_win;
    assign rom_in_win = rom_req.valid && rom_req.offset >= `UIDMAP_ROM_WIN_LO
                        && rom_req.offset <= `UIDMAP_ROM_WIN_HI;

    // base plus ten low offset bits
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rom_rsp <= '0;
        end else begin
            rom_rsp.valid     <= rom_in_win;
            rom_rsp.host_addr <= {rom_base_reg, 10'h000} + {22'h00_0000, rom_req.offset[9:0]};
        end
    end

    //------------------------------------------------------------
    // posted write error capture
    //------------------------------------------------------------
    logic [31:0] fail_low_reg;
    logic [31:0] fail_high_reg;
    always_ff @(posedge core_clk) begin
        if (wr_fail.valid) begin
            fail_low_reg  <= wr_fail.offset[31:0];
            fail_high_reg <= {wr_fail.bus_num, wr_fail.node_num, wr_fail.offset[47:32]};
        end
    end

    //------------------------------------------------------------
    // interrupts
    //------------------------------------------------------------
    logic [`UIDMAP_IRQ_BITS-1:0] irq_stat_reg;
    logic [`UIDMAP_IRQ_BITS-1:0] irq_en_reg;
    logic [`UIDMAP_IRQ_BITS-1:0] irq_set;
    logic [`UIDMAP_IRQ_BITS-1:0] irq_clr;
    assign irq_set = {rom_in_win, wr_fail.valid};
    assign irq_clr = (wr_stb && hit(apb_req.paddr, `UIDMAP_OFF_IRQ_CLEAR))
                     ? apb_req.pwdata[`UIDMAP_IRQ_BITS-1:0] : '0;

    genvar gi;
    generate
        for (gi = 0; gi < `UIDMAP_IRQ_BITS; gi++) begin : g_irq
            // set wins over clear
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    irq_stat_reg[gi] <= 1'b0;
                end else if (irq_set[gi]) begin
                    irq_stat_reg[gi] <= 1'b1;
                end else if (irq_clr[gi]) begin
                    irq_stat_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_en_reg <= '0;
        end else if (wr_stb && hit(apb_req.paddr, `UIDMAP_OFF_IRQ_ENABLE)) begin
            irq_en_reg <= apb_req.pwdata[`UIDMAP_IRQ_BITS-1:0];
        end
    end
    assign irq = |(irq_stat_reg & irq_en_reg);

    //------------------------------------------------------------
    // read mux
    //------------------------------------------------------------
    logic [31:0] rd_next;
    logic        err_next;
    always_comb begin
        rd_next  = 32'h0000_0000;
        err_next = 1'b0;
        if (hit(apb_req.paddr, `UIDMAP_OFF_UID_LOW)) begin
            rd_next = uid_low_reg;
        end else if (hit(apb_req.paddr, `UIDMAP_OFF_ROM_MAP)) begin
            rd_next = {rom_base_reg, 10'h000};
        end else if (hit(apb_req.paddr, `UIDMAP_OFF_FAIL_LOW)) begin
            rd_next = fail_low_reg;
        end else if (hit(apb_req.paddr, `UIDMAP_OFF_FAIL_HIGH)) begin
            rd_next = fail_high_reg;
        end else if (hit(apb_req.paddr, `UIDMAP_OFF_IRQ_STATUS)) begin
            rd_next = {30'h0000_0000, irq_stat_reg};
        end else if (hit(apb_req.paddr, `UIDMAP_OFF_IRQ_ENABLE)) begin
            rd_next = {30'h0000_0000, irq_en_reg};
        end else if (hit(apb_req.paddr, `UIDMAP_OFF_UID_LOAD)) begin
            rd_next = {31'h0000_0000, uid_lock_reg};
        end else if (!hit(apb_req.paddr, `UIDMAP_OFF_IRQ_CLEAR)) begin
            err_next = 1'b1;
        end
    end

    logic [31:0] prdata_reg;
    logic        pslverr_reg;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (setup) begin
            prdata_reg  <= apb_req.pwrite ? 32'h0000_0000 : rd_next;
            pslverr_reg <= err_next;
        end
    end

    assign apb_rsp.pready  = apb_state_reg == UIDMAP_ACCESS;
    assign apb_rsp.prdata  = prdata_reg;
    assign apb_rsp.pslverr = pslverr_reg && apb_state_reg == UIDMAP_ACCESS;

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    AST_UID_LOCKED: assert property (@(posedge core_clk) disable iff (!global_reset_n_n)
        uid_lock_reg |=> $stable(uid_low_reg)) else $error("locked id changed");
    AST_UID_LOAD: assert property (@(posedge core_clk) disable iff (!global_reset_n_n)
        (!uid_lock_reg && id_load_valid) |=> uid_lock_reg && uid_low_reg == $past(chip_serial_low))
        else $error("id not loaded");
    AST_UID_SOFT: assert property (@(posedge core_clk) disable iff (!global_reset_n_n)
        soft_reset |=> $stable(uid_low_reg)) else $error("soft reset changed id");
    AST_MAP_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wr_stb && hit(apb_req.paddr, `UIDMAP_OFF_ROM_MAP) && !soft_reset)
        |=> rom_base_reg == $past(apb_req.pwdata[31:10])) else $error("base not written");
    AST_MAP_XLATE: assert property (@(posedge core_clk) disable iff (!rst_n)
        rom_in_win |=> rom_rsp.valid
        && rom_rsp.host_addr == {$past(rom_base_reg), 10'h000} + {22'h00_0000, $past(rom_req.offset[9:0])})
        else $error("bad rom translation");
    AST_MAP_OUTSIDE: assert property (@(posedge core_clk) disable iff (!rst_n)
        (rom_req.valid && !rom_in_win) |=> !rom_rsp.valid) else $error("out of window mapped");
    AST_MAP_RSVD: assert property (@(posedge core_clk) disable iff (!rst_n)
        (setup && !apb_req.pwrite && hit(apb_req.paddr, `UIDMAP_OFF_ROM_MAP))
        |=> apb_rsp.prdata[9:0] == 10'h000) else $error("reserved bits nonzero");
    AST_FAIL_LOW: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_fail.valid |=> fail_low_reg == $past(wr_fail.offset[31:0])) else $error("low error wrong");
    AST_FAIL_HIGH: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_fail.valid |=> fail_high_reg[31:22] == $past(wr_fail.bus_num)
        && fail_high_reg[21:16] == $past(wr_fail.node_num)) else $error("requester wrong");
    AST_FAIL_OFFHI: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_fail.valid |=> fail_high_reg[15:0] == $past(wr_fail.offset[47:32])) else $error("offset high wrong");
    AST_FAIL_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
        !wr_fail.valid |=> $stable(fail_low_reg) && $stable(fail_high_reg)) else $error("error regs moved");
    AST_FAIL_IRQ: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_fail.valid |=> irq_stat_reg[`UIDMAP_IRQ_WR_FAIL]) else $error("failure not flagged");
    AST_UID_ZERO: assert property (@(posedge core_clk) disable iff (!global_reset_n_n)
        !uid_lock_reg |-> uid_low_reg == `UIDMAP_UID_RESET) else $error("id nonzero before load");

    //------------------------------------------------------------
    // checks on resets, read paths and status flags
    //------------------------------------------------------------
    AST_UID_GLOBAL_RESET_N: assert property (@(posedge core_clk)
        !global_reset_n_n |-> uid_low_reg == `UIDMAP_UID_RESET && !uid_lock_reg)
        else $error("id not cleared by global reset");
    AST_UID_HWRST: assert property (@(posedge core_clk) disable iff (!global_reset_n_n)
        (!rst_n && uid_lock_reg) |=> $stable(uid_low_reg))
        else $error("hardware reset changed id");
    AST_UID_RO: assert property (@(posedge core_clk) disable iff (!global_reset_n_n)
        (wr_stb && hit(apb_req.paddr, `UIDMAP_OFF_UID_LOW) && uid_lock_reg) |=> $stable(uid_low_reg))
        else $error("id written by software");
    AST_UID_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
        (setup && !apb_req.pwrite && hit(apb_req.paddr, `UIDMAP_OFF_UID_LOW))
        |=> apb_rsp.prdata == $past(uid_low_reg)) else $error("id read wrong");
    AST_UID_LOCK_HOLD: assert property (@(posedge core_clk) disable iff (!global_reset_n_n)
        uid_lock_reg |=> uid_lock_reg)
        else $error("id lock dropped");
    AST_MAP_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
        (setup && !apb_req.pwrite && hit(apb_req.paddr, `UIDMAP_OFF_ROM_MAP))
        |=> apb_rsp.prdata[31:10] == $past(rom_base_reg)) else $error("base read wrong");
    AST_MAP_KEEP: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!soft_reset && !(wr_stb && hit(apb_req.paddr, `UIDMAP_OFF_ROM_MAP))) |=> $stable(rom_base_reg))
        else $error("base moved without write");
    AST_MAP_SOFT: assert property (@(posedge core_clk) disable iff (!rst_n)
        soft_reset |=> rom_base_reg == `UIDMAP_MAP_RESET)
        else $error("base kept over soft reset");
    AST_APB_WAIT: assert property (@(posedge core_clk) disable iff (!rst_n)
        setup |=> apb_rsp.pready)
        else $error("access phase not ready");
    AST_ROM_IRQ: assert property (@(posedge core_clk) disable iff (!rst_n)
        rom_in_win |=> irq_stat_reg[`UIDMAP_IRQ_ROM_RD])
        else $error("rom read not flagged");
    AST_ROM_IDLE: assert property (@(posedge core_clk) disable iff (!rst_n)
        !rom_req.valid |=> !rom_rsp.valid)
        else $error("rom answer without request");
    AST_FAIL_PAIR: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_fail.valid |=> {fail_high_reg[15:0], fail_low_reg} == $past(wr_fail.offset))
        else $error("failed offset split wrong");
    AST_FAIL_CLR: assert property (@(posedge core_clk) disable iff (!rst_n)
        (irq_clr[`UIDMAP_IRQ_WR_FAIL] && !irq_set[`UIDMAP_IRQ_WR_FAIL]) |=> !irq_stat_reg[`UIDMAP_IRQ_WR_FAIL])
        else $error("failure flag not cleared");

endmodule

// ### hw/uidmap_regs.svh
// register offsets, field positions, reset values and address windows of the id/rom-map/write-error bank
// assumes inclusion by name from the package or a design file
`ifndef UIDMAP_REGS_SVH
`define UIDMAP_REGS_SVH

`define UIDMAP_OFF_UID_LOW      12'h028
`define UIDMAP_OFF_ROM_MAP      12'h034
`define UIDMAP_OFF_FAIL_LOW     12'h038
`define UIDMAP_OFF_FAIL_HIGH    12'h03c
`define UIDMAP_OFF_IRQ_STATUS   12'h060
`define UIDMAP_OFF_IRQ_CLEAR    12'h064
`define UIDMAP_OFF_IRQ_ENABLE   12'h068
`define UIDMAP_OFF_UID_LOAD     12'h06c

`define UIDMAP_UID_RESET        32'h0000_0000
`define UIDMAP_MAP_RESET        22'h00_0000
`define UIDMAP_MAP_LSB          10
`define UIDMAP_ROM_WIN_LO       48'hffff_f000_0400
`define UIDMAP_ROM_WIN_HI       48'hffff_f000_07ff
`define UIDMAP_BUS_LSB          22
`define UIDMAP_NODE_LSB         16
`define UIDMAP_IRQ_BITS         2
`define UIDMAP_IRQ_WR_FAIL      0
`define UIDMAP_IRQ_ROM_RD       1

`endif

// ### hw/uidmap_pkg.sv
// types of the id/rom-map/write-error bank
// assumes the register header sits beside it
package uidmap_pkg;

    // apb request from the host
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } uidmap_apb_req_t;

    // apb answer to the host
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } uidmap_apb_rsp_t;

    // failed posted write report from the link
    typedef struct packed {
        logic        valid;
        logic [9:0]  bus_num;
        logic [5:0]  node_num;
        logic [47:0] offset;
    } uidmap_wr_fail_t;

    // quadlet read from a remote node
    typedef struct packed {
        logic        valid;
        logic [47:0] offset;
    } uidmap_rom_req_t;

    // translated host address
    typedef struct packed {
        logic        valid;
        logic [31:0] host_addr;
    } uidmap_rom_rsp_t;

    typedef enum logic [1:0] {
        UIDMAP_IDLE   = 2'b00,
        UIDMAP_ACCESS = 2'b01
    } uidmap_apb_state_t;

endpackage

// ### sim/uidmap_link_model.sv
// remote node model: issues config rom quadlet reads and reports failed posted writes
// assumes the bench calls its tasks from one process, after rising edges of core_clk
`timescale 1ns/1ps
module uidmap_link_model (
    // clock
    input  wire logic                        core_clk,
    // link side of the bank
    output      uidmap_pkg::uidmap_rom_req_t rom_req,
    input  wire uidmap_pkg::uidmap_rom_rsp_t rom_rsp,
    output      uidmap_pkg::uidmap_wr_fail_t wr_fail
);
    import uidmap_pkg::*;
    initial begin
        rom_req = '0;
        wr_fail = '0;
    end
    // one read after gap idle cycles; idle offset shows the inverse so stale values never match
    task automatic rom_read(input logic [47:0] off, input int gap, output logic v, output logic [31:0] a);
        repeat (gap) @(posedge core_clk);
        rom_req <= {1'b1, off};
        @(posedge core_clk);
        rom_req <= {1'b0, ~off};
        // the answer stands for one cycle: take it at the next rising edge
        @(posedge core_clk);
        v = rom_rsp.valid;
        a = rom_rsp.host_addr;
    endtask
    // one cycle failure report
    task automatic fail_report(input logic [9:0] bn, input logic [5:0] nn, input logic [47:0] off);
        @(posedge core_clk);
        wr_fail <= {1'b1, bn, nn, off};
        @(posedge core_clk);
        wr_fail <= {1'b0, ~bn, ~nn, ~off};
    endtask
endmodule

// ### sim/ieee1394_link_id_rom_map_write_error_tb_top.sv
// self-checking bench of the id / rom map / write error bank
// assumes the bank, its package and its register header are compiled first
`timescale 1ns/1ps
`include "uidmap_regs.svh"
module ieee1394_link_id_rom_map_write_error_tb_top;
    import uidmap_pkg::*;
    logic            core_clk = 1'b0;
    logic            rst_b = 1'b0;
    logic            global_reset_n = 1'b0;
    logic            soft_reset = 1'b0;
    logic            id_load_valid = 1'b0;
    logic [31:0]     chip_serial_low = 32'h0;
    logic            irq;
    uidmap_apb_req_t apb_req = '0;
    uidmap_apb_rsp_t apb_rsp;
    uidmap_rom_req_t rom_req;
    uidmap_rom_rsp_t rom_rsp;
    uidmap_wr_fail_t wr_fail;
    int              err_total = 0;
    int              tests_run = 0;

    always #4 core_clk = ~core_clk;

    uidmap_bank uidmap_bank_i (.core_clk(core_clk), .rst_b(rst_b), .global_reset_n(global_reset_n),
        .soft_reset(soft_reset), .apb_req(apb_req), .apb_rsp(apb_rsp), .id_load_valid(id_load_valid),
        .chip_serial_low(chip_serial_low), .rom_req(rom_req), .rom_rsp(rom_rsp), .wr_fail(wr_fail), .irq(irq));
    uidmap_link_model uidmap_link_model_i (.core_clk(core_clk), .rom_req(rom_req), .rom_rsp(rom_rsp),
        .wr_fail(wr_fail));

    //------------------------------------------------------------
    // shared tasks
    //------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // setup cycle, then access held until pready is sampled high at a rising edge; data taken at that edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        n = 0;
        @(posedge core_clk);
        apb_req <= {1'b1, 1'b0, w, a, d};
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 50);
        q = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_req <= '0;
        if (apb_rsp.pready !== 1'b1) chk("pready", 32'h1, 32'h0);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(nm, exp, q);
    endtask
    task automatic load_id(input logic [31:0] v);
        @(posedge core_clk);
        chip_serial_low <= v;
        id_load_valid <= 1'b1;
        @(posedge core_clk);
        id_load_valid <= 1'b0;
    endtask

    //------------------------------------------------------------
    // scenarios
    //------------------------------------------------------------
    task automatic t_id();
        rdchk("id reset", `UIDMAP_OFF_UID_LOW, 32'h0);
        rdchk("map reset", `UIDMAP_OFF_ROM_MAP, 32'h0);
        load_id(32'h5a3c_96e1);
        load_id(32'h1234_5678);
        rdchk("id locked", `UIDMAP_OFF_UID_LOW, 32'h5a3c_96e1);
        wr(`UIDMAP_OFF_UID_LOW, 32'hffff_ffff);
        rdchk("id read only", `UIDMAP_OFF_UID_LOW, 32'h5a3c_96e1);
        @(posedge core_clk);
        soft_reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        soft_reset <= 1'b0;
        rdchk("id soft reset", `UIDMAP_OFF_UID_LOW, 32'h5a3c_96e1);
        global_reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        global_reset_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        rdchk("id global reset", `UIDMAP_OFF_UID_LOW, 32'h0);
        load_id(32'h0f1e_2d3c);
        rdchk("id reload", `UIDMAP_OFF_UID_LOW, 32'h0f1e_2d3c);
        $display("test id done");
    endtask
    task automatic t_rom();
        logic [47:0] offs [5] = '{48'hffff_f000_0400, 48'hffff_f000_07ff, 48'hffff_f000_05a4,
                                  48'hffff_f000_03fc, 48'hffff_f000_0800};
        logic        v;
        logic [31:0] a;
        wr(`UIDMAP_OFF_ROM_MAP, 32'hffff_ffff);
        rdchk("map reserved", `UIDMAP_OFF_ROM_MAP, 32'hffff_fc00);
        wr(`UIDMAP_OFF_ROM_MAP, 32'h8765_4321);
        rdchk("map base", `UIDMAP_OFF_ROM_MAP, 32'h8765_4000);
        for (int i = 0; i < 5; i++) begin
            uidmap_link_model_i.rom_read(offs[i], i * 3, v, a);
            chk("rom hit", {31'h0, i < 3}, {31'h0, v});
            if (i < 3) chk("rom addr", 32'h8765_4000 + {22'h0, offs[i][9:0]}, a);
        end
        @(posedge core_clk);
        soft_reset <= 1'b1;
        @(posedge core_clk);
        soft_reset <= 1'b0;
        rdchk("map soft reset", `UIDMAP_OFF_ROM_MAP, 32'h0);
        $display("test rom done");
    endtask
    task automatic t_fail();
        logic [31:0] q;
        logic        e;
        logic        v;
        wr(`UIDMAP_OFF_IRQ_ENABLE, 32'h1);
        uidmap_link_model_i.fail_report(10'h2a5, 6'h1b, 48'hfedc_ba98_7654);
        rdchk("fail low", `UIDMAP_OFF_FAIL_LOW, 32'hba98_7654);
        rdchk("fail high", `UIDMAP_OFF_FAIL_HIGH, {10'h2a5, 6'h1b, 16'hfedc});
        chk("irq on", 32'h1, {31'h0, irq});
        rdchk("status", `UIDMAP_OFF_IRQ_STATUS, 32'h3);
        uidmap_link_model_i.rom_read(48'hffff_f000_0410, 0, v, q);
        wr(`UIDMAP_OFF_FAIL_HIGH, 32'h0);
        rdchk("fail hold", `UIDMAP_OFF_FAIL_HIGH, {10'h2a5, 6'h1b, 16'hfedc});
        uidmap_link_model_i.fail_report(10'h15a, 6'h24, 48'h0123_4567_89ab);
        rdchk("fail low 2", `UIDMAP_OFF_FAIL_LOW, 32'h4567_89ab);
        rdchk("fail high 2", `UIDMAP_OFF_FAIL_HIGH, {10'h15a, 6'h24, 16'h0123});
        wr(`UIDMAP_OFF_IRQ_CLEAR, 32'h1);
        #1;
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr(`UIDMAP_OFF_IRQ_ENABLE, 32'h0);
        uidmap_link_model_i.fail_report(10'h3ff, 6'h3f, 48'hffff_ffff_fffc);
        rdchk("status masked", `UIDMAP_OFF_IRQ_STATUS, 32'h3);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b0, 12'h070, 32'h0, q, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        $display("test fail done");
    endtask

    initial begin
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        global_reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_id();
        t_rom();
        t_fail();
        end_of_test();
    end
    initial begin
        #(5000 * 8);
        err_total++;
        end_of_test();
    end
endmodule
